// file: hw/sleep_wakeup_source_control.sv
// Wakeup source control for the sleep states: enables, pin edges, RTC interval.
// Assumes an 8-bit CPU register port and a 62.5 ms tick from the RTC.
`timescale 1ns/1ps
`default_nettype none
`include "wake_params.svh"

module sleep_wakeup_source_control
  import wake_pkg::*;
#(
  parameter int TICK_WIDTH = 21
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // CPU register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  // Sleep controls
  input  wire logic       sleepEnter,
  input  wire logic [7:0] sleepCtrl,
  output logic      [7:0] sleepCtrlCleared,
  output logic            sleepCtrlClearStrobe,
  // Wake sources
  input  wire logic       energyPulseOutput,
  input  wire logic       wakePinFour,
  input  wire logic       wakePinThree,
  input  wire logic       rtcTick,
  // Wake results
  output logic            wakeResume,
  output logic            wakeReset,
  output logic            selectCrystalClock,
  output logic            sleeping
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0]        intervalSel_r, intervalSel_nxt;
  logic [7:0]        edgeSel_r, edgeSel_nxt;
  logic [2:0]        srcCtrl_r, srcCtrl_nxt;
  logic [7:0]        rtc_seconds_wake_interval_r, rtc_seconds_wake_interval_nxt;
  logic [7:0]        rdata_nxt;
  wake_state_e       state_r, state_nxt;
  logic [TICK_WIDTH-1:0] tickCnt_r, tickCnt_nxt;
  logic [TICK_WIDTH-1:0] tickLimit;
  logic              resume_nxt, reset_nxt, xtal_nxt, clrStb_nxt;
  logic [7:0]        clrVal_nxt;
  logic              rtcEvent, ioEvent, pulseEvent;

  edge_detect_if ed ();

  assign ed.pinLevel = {wakePinFour, wakePinThree};
  assign ed.edgeSel  = edgeSel_r[`EDGE_PIN_FOUR_HI:`EDGE_PIN_THREE_HI - 1];

  wake_edge_detect u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ed    (ed)
  );

  always_comb begin
    intervalSel_nxt = intervalSel_r;
    edgeSel_nxt     = edgeSel_r;
    srcCtrl_nxt     = srcCtrl_r;
    rtc_seconds_wake_interval_nxt      = rtc_seconds_wake_interval_r;
    if (regWrite) begin
      case (regAddr)
        `ADDR_RTC_WAKE_INTERVAL_SELECT:  intervalSel_nxt = regWdata;
        `ADDR_WAKE_PIN_EDGE_SELECT:      edgeSel_nxt     = regWdata;
        `ADDR_WAKE_SOURCE_CONTROL:       srcCtrl_nxt     = regWdata[2:0];
        `ADDR_RTC_SECONDS_WAKE_INTERVAL: rtc_seconds_wake_interval_nxt      = regWdata;
        default:                         ;
      endcase
    end
    case (regAddr)
      `ADDR_RTC_WAKE_INTERVAL_SELECT:  rdata_nxt = intervalSel_r;
      `ADDR_WAKE_PIN_EDGE_SELECT:      rdata_nxt = edgeSel_r;
      `ADDR_WAKE_SOURCE_CONTROL:       rdata_nxt = {5'h00, srcCtrl_r};
      `ADDR_RTC_SECONDS_WAKE_INTERVAL: rdata_nxt = rtc_seconds_wake_interval_r;
      default:                         rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intervalSel_r <= `RST_RTC_WAKE_INTERVAL_SELECT;
      edgeSel_r     <= `RST_WAKE_PIN_EDGE_SELECT;
      srcCtrl_r     <= 3'h0;
      rtc_seconds_wake_interval_r      <= `RST_RTC_SECONDS_WAKE_INTERVAL;
      regRdata      <= 8'h00;
    end else begin
      intervalSel_r <= intervalSel_nxt;
      edgeSel_r     <= edgeSel_nxt;
      srcCtrl_r     <= srcCtrl_nxt;
      rtc_seconds_wake_interval_r      <= rtc_seconds_wake_interval_nxt;
      regRdata      <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // RTC interval, counted in 62.5 ms ticks
  // ----------------------------------------------------------------
  // Seconds mode only honoured with select at seven, so a stray bit cannot alter the code
  logic secMode;
  assign secMode = rtc_seconds_wake_interval_r[`BIT_SECONDS_MODE] && (intervalSel_r[2:0] == `SECONDS_MODE_SELECT);

  always_comb begin
    if (secMode) begin
      if (rtc_seconds_wake_interval_r[5:0] == 6'h00)
        tickLimit = TICK_WIDTH'(1);
      else
        tickLimit = TICK_WIDTH'((rtc_seconds_wake_interval_r[5:0] + 7'd1) * `TICKS_PER_SECOND);
    end else begin
      case (intervalSel_r[2:0])
        3'h0:    tickLimit = TICK_WIDTH'(`TICKS_PER_SECOND);
        3'h1:    tickLimit = TICK_WIDTH'(60 * `TICKS_PER_SECOND);
        3'h2:    tickLimit = TICK_WIDTH'(3600 * `TICKS_PER_SECOND);
        3'h3:    tickLimit = TICK_WIDTH'(86400 * `TICKS_PER_SECOND);
        3'h4:    tickLimit = TICK_WIDTH'(8);
        3'h5:    tickLimit = TICK_WIDTH'(4);
        3'h6:    tickLimit = TICK_WIDTH'(2);
        default: tickLimit = TICK_WIDTH'(1);
      endcase
    end
  end

  assign rtcEvent   = rtcTick && (tickCnt_r + TICK_WIDTH'(1) >= tickLimit);
  assign pulseEvent = energyPulseOutput && srcCtrl_r[`BIT_ENERGY_PULSE_WAKE_ENABLE];
  assign ioEvent    = (|ed.pinEvent) && srcCtrl_r[`BIT_PORT_ZERO_WAKE_ENABLE];

  // ----------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    tickCnt_nxt = tickCnt_r;
    resume_nxt  = 1'b0;
    reset_nxt   = 1'b0;
    xtal_nxt    = 1'b0;
    clrStb_nxt  = 1'b0;
    clrVal_nxt  = sleepCtrlCleared;
    case (state_r)
      AWAKE: begin
        tickCnt_nxt = '0;
        if (sleepEnter)
          state_nxt = SLEEPING;
      end
      SLEEPING: begin
        if (rtcTick)
          tickCnt_nxt = rtcEvent ? '0 : tickCnt_r + TICK_WIDTH'(1);
        if (ioEvent) begin
          state_nxt = WAKING;
          if (srcCtrl_r[`BIT_IO_WAKE_RESUME_MODE]) begin
            resume_nxt = 1'b1;
            clrStb_nxt = 1'b1;
            clrVal_nxt = sleepCtrl & ~`SLEEP_BITS_CLEAR_MASK;
          end else begin
            reset_nxt = 1'b1;
            xtal_nxt  = 1'b1;
          end
        end else if (pulseEvent || rtcEvent) begin
          state_nxt  = WAKING;
          resume_nxt = 1'b1;
        end
      end
      WAKING:  state_nxt = AWAKE;
      default: state_nxt = AWAKE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r              <= AWAKE;
      tickCnt_r            <= '0;
      wakeResume           <= 1'b0;
      wakeReset            <= 1'b0;
      selectCrystalClock   <= 1'b0;
      sleepCtrlClearStrobe <= 1'b0;
      sleepCtrlCleared     <= 8'h00;
      sleeping             <= 1'b0;
    end else begin
      state_r              <= state_nxt;
      tickCnt_r            <= tickCnt_nxt;
      wakeResume           <= resume_nxt;
      wakeReset            <= reset_nxt;
      selectCrystalClock   <= xtal_nxt;
      sleepCtrlClearStrobe <= clrStb_nxt;
      sleepCtrlCleared     <= clrVal_nxt;
      sleeping             <= (state_nxt == SLEEPING);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pulse_gate;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && energyPulseOutput && !srcCtrl_r[`BIT_ENERGY_PULSE_WAKE_ENABLE]
       && !ioEvent && !rtcEvent) |=> !wakeResume;
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("pulse woke while disabled");

  property p_io_gate;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && !srcCtrl_r[`BIT_PORT_ZERO_WAKE_ENABLE] && !pulseEvent && !rtcEvent)
      |=> !wakeResume && !wakeReset;
  endproperty
  a_io_gate: assert property (p_io_gate) else $error("pin woke while disabled");

  property p_resume;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && ioEvent && srcCtrl_r[`BIT_IO_WAKE_RESUME_MODE])
      |=> wakeResume && !wakeReset ##1 !wakeResume;
  endproperty
  a_resume: assert property (p_resume) else $error("resume wake wrong");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
      sleepCtrlClearStrobe |-> (sleepCtrlCleared & `SLEEP_BITS_CLEAR_MASK) == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("sleep bits not cleared");

  property p_reset_wake;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && ioEvent && !srcCtrl_r[`BIT_IO_WAKE_RESUME_MODE])
      |=> wakeReset && selectCrystalClock && !sleepCtrlClearStrobe;
  endproperty
  a_reset_wake: assert property (p_reset_wake) else $error("reset wake wrong");

  property p_fast_tick;
    @(posedge clk) disable iff (!rst_n)
      (!secMode && intervalSel_r[2:0] == 3'h7) |-> tickLimit == TICK_WIDTH'(1);
  endproperty
  a_fast_tick: assert property (p_fast_tick) else $error("62.5 ms code wrong");

  property p_sec;
    @(posedge clk) disable iff (!rst_n)
      (secMode && rtc_seconds_wake_interval_r[5:0] != 6'h00)
      |-> tickLimit == TICK_WIDTH'((rtc_seconds_wake_interval_r[5:0] + 7'd1) * 16);
  endproperty
  a_sec: assert property (p_sec) else $error("seconds interval wrong");

  property p_sec_zero;
    @(posedge clk) disable iff (!rst_n)
      (secMode && rtc_seconds_wake_interval_r[5:0] == 6'h00) |-> tickLimit == TICK_WIDTH'(1);
  endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("zero seconds interval wrong");

  property p_awake_quiet;
    @(posedge clk) disable iff (!rst_n)
      (state_r == AWAKE) |=> !wakeResume && !wakeReset;
  endproperty
  a_awake_quiet: assert property (p_awake_quiet) else $error("wake while awake");

  property p_pulse_wake;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && pulseEvent && !ioEvent)
      |=> wakeResume && !wakeReset && !sleepCtrlClearStrobe;
  endproperty
  a_pulse_wake: assert property (p_pulse_wake) else $error("pulse wake missing");

  property p_pin_wake;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && (|ed.pinEvent) && srcCtrl_r[`BIT_PORT_ZERO_WAKE_ENABLE])
      |=> wakeResume || wakeReset;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake missing");

  // Other sleep control bits must pass through untouched
  property p_keep_bits;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && ioEvent && srcCtrl_r[`BIT_IO_WAKE_RESUME_MODE])
      |=> sleepCtrlCleared == ($past(sleepCtrl) & ~`SLEEP_BITS_CLEAR_MASK);
  endproperty
  a_keep_bits: assert property (p_keep_bits) else $error("sleep control bits not kept");

  property p_tick_count;
    @(posedge clk) disable iff (!rst_n)
      (state_r == SLEEPING && rtcTick && !rtcEvent)
      |=> tickCnt_r == $past(tickCnt_r) + TICK_WIDTH'(1);
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("tick count wrong");

  property p_sleep_enter;
    @(posedge clk) disable iff (!rst_n)
      (state_r == AWAKE && sleepEnter) |=> sleeping;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");

  property p_rise_four;
    @(posedge clk) disable iff (!rst_n)
      (edgeSel_r[`EDGE_PIN_FOUR_HI -: 2] == 2'h1 && $rose(wakePinFour)) |=> ed.pinEvent[1];
  endproperty
  a_rise_four: assert property (p_rise_four) else $error("pin four rise missed");

  property p_fall_three;
    @(posedge clk) disable iff (!rst_n)
      (edgeSel_r[`EDGE_PIN_THREE_HI -: 2] != 2'h1 && $fell(wakePinThree)) |=> ed.pinEvent[0];
  endproperty
  a_fall_three: assert property (p_fall_three) else $error("pin three fall missed");
endmodule
`default_nettype wire

// file: hw/wake_params.svh
// Register offsets, field positions, reset values and timing counts of the wake control block.
// Assumes an 8-bit special function register port driven by the on-chip CPU.
`ifndef WAKE_PARAMS_SVH
`define WAKE_PARAMS_SVH

`define ADDR_RTC_WAKE_INTERVAL_SELECT  8'h96
`define ADDR_WAKE_PIN_EDGE_SELECT      8'hc7
`define ADDR_WAKE_SOURCE_CONTROL       8'hc9
`define ADDR_RTC_SECONDS_WAKE_INTERVAL 8'hdf

`define RST_RTC_WAKE_INTERVAL_SELECT   8'h00
`define RST_WAKE_PIN_EDGE_SELECT       8'h00
`define RST_WAKE_SOURCE_CONTROL        8'h00
`define RST_RTC_SECONDS_WAKE_INTERVAL  8'h00

`define BIT_ENERGY_PULSE_WAKE_ENABLE   2
`define BIT_PORT_ZERO_WAKE_ENABLE      1
`define BIT_IO_WAKE_RESUME_MODE        0
`define BIT_SECONDS_MODE               6
`define SECONDS_MODE_SELECT            3'h7

`define EDGE_PIN_FOUR_HI               7
`define EDGE_PIN_THREE_HI              5

`define SLEEP_BITS_CLEAR_MASK          8'h66

// Tick clock period 62.5 ms in microseconds; all intervals are multiples of it
`define TICK_PERIOD_US                 62500
`define CLK_PERIOD_NS                  20
`define TICKS_PER_SECOND               16

`endif

// file: hw/wake_pkg.sv
// Types shared by the wake control block.
// Assumes nothing of its surroundings.
package wake_pkg;
  typedef enum logic [2:0] {
    AWAKE    = 3'b001,
    SLEEPING = 3'b010,
    WAKING   = 3'b100
  } wake_state_e;

  typedef logic [1:0] edge_code_t;
endpackage

// file: hw/edge_detect_if.sv
// Interface between the wake controller and its pin edge detector.
// Assumes both ends run on one clock.
`timescale 1ns/1ps
`default_nettype none
interface edge_detect_if;
  logic [1:0] pinLevel;
  logic [3:0] edgeSel;
  logic [1:0] pinEvent;
  modport ctrl (output pinLevel, output edgeSel, input pinEvent);
  modport det  (input pinLevel, input edgeSel, output pinEvent);
endinterface
`default_nettype wire

// file: hw/wake_edge_detect.sv
// Per-pin edge detector for the two port-zero wakeup pins.
// Assumes pin levels already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module wake_edge_detect
  import wake_pkg::*;
(
  // Clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // Controller side
  edge_detect_if.det ed
);
  logic [1:0] prevLevel_r;
  logic [1:0] prevLevel_nxt;
  logic [1:0] pinEvent_r;
  logic [1:0] pinEvent_nxt;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      edge_code_t sel;
      logic       rise;
      logic       fall;
      assign sel  = ed.edgeSel[2*g+1 -: 2];
      assign rise = ed.pinLevel[g] & ~prevLevel_r[g];
      assign fall = ~ed.pinLevel[g] & prevLevel_r[g];
      always_comb begin
        prevLevel_nxt[g] = ed.pinLevel[g];
        case (sel)
          2'h1:    pinEvent_nxt[g] = rise;
          2'h2:    pinEvent_nxt[g] = rise | fall;
          default: pinEvent_nxt[g] = fall;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevLevel_r <= 2'h3;
      pinEvent_r  <= 2'h0;
    end else begin
      prevLevel_r <= prevLevel_nxt;
      pinEvent_r  <= pinEvent_nxt;
    end
  end

  assign ed.pinEvent = pinEvent_r;
endmodule
`default_nettype wire

// file: bench/sleep_wakeup_source_control_tb.sv
// Self-checking bench for the sleep wakeup source control block.
// Assumes the hw/ package, header and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "wake_params.svh"
module sleep_wakeup_source_control_tb
  import wake_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       regWrite = 1'b0;
  logic       sleepEnter = 1'b0;
  logic       energyPulseOutput = 1'b0;
  logic       rtcTick = 1'b0;
  logic [1:0] pins = 2'b11;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] sleepCtrl = 8'hff;
  logic [7:0] regRdata;
  logic [7:0] sleepCtrlCleared;
  logic       sleepCtrlClearStrobe;
  logic       wakeResume;
  logic       wakeReset;
  logic       selectCrystalClock;
  logic       sleeping;
  int         badCount = 0;
  int         totalChecks = 0;
  int         n;
  logic [7:0] addrs [4] = '{8'h96, 8'hc7, 8'hc9, 8'hdf};
  // Select, seconds field, expected ticks; ticks come every cycle
  int         cfg [11][3] = '{'{0, 0, 16}, '{1, 0, 960}, '{2, 0, 57600}, '{4, 0, 8}, '{5, 0, 4},
                              '{6, 0, 2}, '{7, 0, 1}, '{7, 'h41, 32}, '{7, 'h7f, 1024},
                              '{7, 'h40, 1}, '{0, 'h41, 16}};

  always #10 clk = ~clk;

  sleep_wakeup_source_control DUT (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata),
    .regRdata(regRdata), .sleepEnter(sleepEnter), .sleepCtrl(sleepCtrl),
    .sleepCtrlCleared(sleepCtrlCleared), .sleepCtrlClearStrobe(sleepCtrlClearStrobe),
    .energyPulseOutput(energyPulseOutput), .wakePinFour(pins[1]), .wakePinThree(pins[0]),
    .rtcTick(rtcTick), .wakeResume(wakeResume), .wakeReset(wakeReset),
    .selectCrystalClock(selectCrystalClock), .sleeping(sleeping)
  );

  // ----------------------------------------
  // Checking and access tasks
  // ----------------------------------------
  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  // Read data is registered, so look one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    @(posedge clk);
    #1 chk8("regRdata", exp, regRdata);
  endtask

  task automatic sleepNow();
    @(posedge clk);
    sleepEnter <= 1'b1;
    @(posedge clk);
    sleepEnter <= 1'b0;
    #1 chk1("sleeping", 1'b1, sleeping);
  endtask

  task automatic pulse();
    @(posedge clk);
    energyPulseOutput <= 1'b1;
    @(posedge clk);
    energyPulseOutput <= 1'b0;
  endtask

  // Step past the edge first, so a pulse launched there is not missed
  task automatic waitWake(input int lim);
    n = 0;
    #1;
    while (n < lim && wakeResume !== 1'b1 && wakeReset !== 1'b1) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic noWake(input int lim);
    waitWake(lim);
    chk1("unexpected wake", 1'b0, wakeResume | wakeReset);
  endtask

  // Timeout here ends the run; a stuck sleep would hang everything after
  task automatic expectWake(input int lim, input logic rs, input logic clr);
    waitWake(lim);
    if (wakeResume !== 1'b1 && wakeReset !== 1'b1) begin
      chk1("wake", 1'b1, 1'b0);
      endSim();
    end else begin
      chk1("wakeReset", rs, wakeReset);
      chk1("crystal", rs, selectCrystalClock);
      chk1("wakeResume", !rs, wakeResume);
      chk1("sleeping", 1'b0, sleeping);
      chk1("clrStrobe", clr, sleepCtrlClearStrobe);
      if (clr)
        chk8("cleared", 8'h99, sleepCtrlCleared);
      repeat (3) @(posedge clk);
    end
  endtask

  task automatic pinWake(input int idx, input logic [1:0] code, input logic rs);
    wr(`ADDR_WAKE_PIN_EDGE_SELECT, idx ? {code, 6'h00} : {2'b00, code, 4'h0});
    wr(`ADDR_WAKE_SOURCE_CONTROL, {7'h01, !rs});
    sleepNow();
    @(posedge clk) pins[idx] <= 1'b0;
    if (code == 2'b01) begin
      noWake(6);
      @(posedge clk) pins[idx] <= 1'b1;
    end
    expectWake(4, rs, !rs);
    chk1("latency", 1'b1, n == 2);
    if (code == 2'b10) begin
      sleepNow();
      @(posedge clk) pins[idx] <= 1'b1;
      expectWake(4, rs, !rs);
    end
    @(posedge clk) pins[idx] <= 1'b1;
    noWake(6);
  endtask

  task automatic rtcRun(input int sel, input int sec, input int lim);
    wr(`ADDR_RTC_WAKE_INTERVAL_SELECT, sel[7:0]);
    wr(`ADDR_RTC_SECONDS_WAKE_INTERVAL, sec[7:0]);
    sleepNow();
    @(posedge clk) rtcTick <= 1'b1;
    expectWake(lim + 3, 1'b0, 1'b0);
    rtcTick <= 1'b0;
    chk1("rtc interval", 1'b1, n == lim);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    foreach (addrs[i]) begin
      wr(addrs[i], 8'ha5);
      rd(addrs[i], i == 2 ? 8'h05 : 8'ha5);
    end
    wr(8'h00, 8'h55);
    rd(8'h00, 8'h00);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++)
        pinWake(p, c[1:0], c[0]);
    wr(`ADDR_WAKE_SOURCE_CONTROL, 8'h05);
    pulse();
    noWake(6);
    sleepNow();
    @(posedge clk) pins[0] <= 1'b0;
    noWake(6);
    pulse();
    expectWake(4, 1'b0, 1'b0);
    @(posedge clk) pins[0] <= 1'b1;
    wr(`ADDR_WAKE_SOURCE_CONTROL, 8'h03);
    sleepNow();
    pulse();
    noWake(6);
    @(posedge clk) pins[1] <= 1'b0;
    expectWake(4, 1'b0, 1'b1);
    @(posedge clk) pins[1] <= 1'b1;
    wr(`ADDR_WAKE_SOURCE_CONTROL, 8'h00);
    foreach (cfg[i]) rtcRun(cfg[i][0], cfg[i][1], cfg[i][2]);
    wr(`ADDR_RTC_WAKE_INTERVAL_SELECT, 8'h03);
    wr(`ADDR_WAKE_SOURCE_CONTROL, 8'h03);
    sleepNow();
    @(posedge clk) rtcTick <= 1'b1;
    noWake(2000);
    @(posedge clk) begin
      rtcTick <= 1'b0;
      pins[0] <= 1'b0;
    end
    expectWake(4, 1'b0, 1'b1);
    endSim();
  end
endmodule
`default_nettype wire
